// >>> ssf_filter.sv
// Purpose: Scaling, standstill and smoothing stage of a speed meter
// Assumes: sample_valid pulses once per measuring cycle on mclk
// Notes: Registers on AXI4-Lite; result refreshed per display cycle
// Function
// - Filter setting 0 passes each new scaled value straight through.
// - Filter setting 1 outputs the mean of the two newest samples.
// - Filter setting 3 outputs the mean of the eight newest samples.
// - Filter setting 5 is an exponential filter with a two-sample time constant.
// - Speed is zero when the input frequency is below one over the standstill time.
// - The displayed value is refreshed once per display cycle time.
// - Frequency is scaled so reference frequency maps to reference display value.
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module ssf_filter
    import ssf_pkg::*;
#(
    parameter int unsigned MS_CYC = ssf_pkg::MS_CYCLES
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sample_valid,
    input wire logic [31:0] sample_freq,
    output logic [31:0] display_value,
    output logic display_strobe,
    output logic channel_sync_enable,
    input wire logic [ssf_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ssf_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import ssf_pkg::*;

    typedef struct packed {
        ssf_state_t state;
        logic [63:0] div_num;
        logic [32:0] div_rem;
        logic [63:0] div_quo;
        logic [6:0] div_cnt;
        logic [31:0] sample;
        logic [2:0] mode;
        logic sync;
        logic [31:0] disp_cycle, standstill, ref_freq, ref_disp;
        logic [2:0] applied_mode;
        logic [31:0] prev;
        logic [34:0] sum;
        logic [3:0] fill;
        logic [2:0] wr_ptr;
        logic [39:0] exp_fx;
        logic [31:0] filt, ms_div, ms_cnt, disp;
        logic disp_stb;
        logic aw_got, w_got;
        logic aw_rdy, w_rdy, ar_rdy;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ssf_regs_t;

    ssf_regs_t r_ff, nxt_r;
    logic [31:0] hist_old;

    // Byte-lane merge for register writes
    function automatic logic [31:0] ssf_merge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Offset decode shared by read and write paths
    function automatic logic ssf_mapped(input logic [7:0] addr);
        return (addr[1:0] == 2'h0) && (addr <= OFS_SAMPLE);
    endfunction

    ssf_hist_mem #(.WIDTH(32), .DEPTH(AVG8_DEPTH), .AW(3)) u_hist (
        .mclk(mclk),
        .wr_en(r_ff.state == ST_FILT),
        .wr_addr(r_ff.wr_ptr),
        .wr_data(r_ff.sample),
        .rd_addr(r_ff.wr_ptr),
        .rd_data_ff(hist_old)
    );

    // Next-state logic for the whole block
    always_comb begin
        logic [63:0] ss_prod;
        logic [32:0] rem_sh, avg2;
        logic clr;
        logic [31:0] prev_h, old, period, wcur, wnew;
        logic [34:0] sum_h;
        logic [3:0] fill_h;
        logic [39:0] exp_h;
        logic signed [49:0] e_s, x_s, prod;
        nxt_r = r_ff;
        nxt_r.disp_stb = 1'b0;
        ss_prod = 64'(sample_freq) * 64'(r_ff.standstill);
        rem_sh = {r_ff.div_rem[31:0], r_ff.div_num[63]};
        clr = (r_ff.mode != r_ff.applied_mode);
        prev_h = clr ? 32'h0 : r_ff.prev;
        sum_h = clr ? 35'h0 : r_ff.sum;
        fill_h = clr ? 4'h0 : r_ff.fill;
        exp_h = clr ? 40'h0 : r_ff.exp_fx;
        old = (fill_h == AVG8_FULL) ? hist_old : 32'h0;
        avg2 = ({1'b0, r_ff.sample} + {1'b0, prev_h}) >> 1;
        e_s = $signed({10'h0, exp_h});
        x_s = $signed({10'h0, r_ff.sample, 8'h00});
        prod = (x_s - e_s) * $signed(EXP_NUM);
        period = (r_ff.disp_cycle == 32'h0) ? 32'h1 : r_ff.disp_cycle;
        wcur = 32'h0;
        wnew = 32'h0;

        // Sample path: scale, then smooth
        unique case (r_ff.state)
            ST_IDLE: begin
                // Samples arriving while busy are dropped; the divider is
                // far quicker than any measuring cycle
                if (sample_valid) begin
                    nxt_r.div_num = 64'(sample_freq) * 64'(r_ff.ref_disp);
                    nxt_r.div_rem = 33'h0;
                    nxt_r.div_quo = 64'h0;
                    nxt_r.div_cnt = 7'h0;
                    if ((r_ff.standstill != 32'h0 && ss_prod < STANDSTILL_SCALE) ||
                        r_ff.ref_freq == 32'h0) begin
                        nxt_r.sample = 32'h0;
                        nxt_r.state = ST_FILT;
                    end else begin
                        nxt_r.state = ST_DIV;
                    end
                end
            end
            ST_DIV: begin
                // Restoring division, one quotient bit per clock
                nxt_r.div_num = {r_ff.div_num[62:0], 1'b0};
                if (rem_sh >= {1'b0, r_ff.ref_freq}) begin
                    nxt_r.div_rem = rem_sh - {1'b0, r_ff.ref_freq};
                    nxt_r.div_quo = {r_ff.div_quo[62:0], 1'b1};
                end else begin
                    nxt_r.div_rem = rem_sh;
                    nxt_r.div_quo = {r_ff.div_quo[62:0], 1'b0};
                end
                nxt_r.div_cnt = r_ff.div_cnt + 7'h1;
                if (r_ff.div_cnt == DIV_STEPS - 7'h1) begin
                    // Saturate rather than wrap on overflow
                    nxt_r.sample = (nxt_r.div_quo[63:32] != 32'h0) ? 32'hFFFF_FFFF
                                                                     : nxt_r.div_quo[31:0];
                    nxt_r.state = ST_FILT;
                end
            end
            ST_FILT: begin
                // One filter step per measuring cycle
                nxt_r.applied_mode = r_ff.mode;
                nxt_r.prev = r_ff.sample;
                nxt_r.sum = sum_h + 35'(r_ff.sample) - 35'(old);
                nxt_r.fill = (fill_h == AVG8_FULL) ? fill_h : fill_h + 4'h1;
                nxt_r.wr_ptr = r_ff.wr_ptr + 3'h1;
                nxt_r.exp_fx = 40'(e_s + (prod >>> EXP_SHIFT));
                unique case (r_ff.mode)
                    FMODE_AVG2: nxt_r.filt = avg2[31:0];
                    FMODE_AVG8: nxt_r.filt = 32'(nxt_r.sum >> AVG8_SHIFT);
                    FMODE_EXP: nxt_r.filt = nxt_r.exp_fx[39:8];
                    default: nxt_r.filt = r_ff.sample;
                endcase
                nxt_r.state = ST_IDLE;
            end
            default: nxt_r.state = ST_IDLE;
        endcase

        // Display refresh timer in milliseconds
        if (r_ff.ms_div >= MS_CYC - 1) begin
            nxt_r.ms_div = 32'h0;
            if (r_ff.ms_cnt + 32'h1 >= period) begin
                nxt_r.ms_cnt = 32'h0;
                nxt_r.disp = r_ff.filt;
                nxt_r.disp_stb = 1'b1;
            end else begin
                nxt_r.ms_cnt = r_ff.ms_cnt + 32'h1;
            end
        end else begin
            nxt_r.ms_div = r_ff.ms_div + 32'h1;
        end

        // Write address and data may arrive in either order
        if (s_axi_awvalid && !r_ff.aw_got && !r_ff.bvalid) begin
            nxt_r.aw_got = 1'b1;
            nxt_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r_ff.w_got && !r_ff.bvalid) begin
            nxt_r.w_got = 1'b1;
            nxt_r.wdata = s_axi_wdata;
            nxt_r.wstrb = s_axi_wstrb;
        end
        if (r_ff.aw_got && r_ff.w_got) begin
            nxt_r.aw_got = 1'b0;
            nxt_r.w_got = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = ssf_mapped(r_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (r_ff.awaddr)
                OFS_CTRL: wcur = {23'h0, r_ff.sync, 5'h0, r_ff.mode};
                OFS_DISP_CYCLE: wcur = r_ff.disp_cycle;
                OFS_STANDSTILL: wcur = r_ff.standstill;
                OFS_REF_FREQ: wcur = r_ff.ref_freq;
                OFS_REF_DISP: wcur = r_ff.ref_disp;
                default: wcur = 32'h0;
            endcase
            wnew = ssf_merge(wcur, r_ff.wdata, r_ff.wstrb);
            unique case (r_ff.awaddr)
                OFS_CTRL: begin
                    nxt_r.mode = wnew[CTRL_MODE_LSB +: CTRL_MODE_W];
                    nxt_r.sync = wnew[CTRL_SYNC_BIT];
                end
                OFS_DISP_CYCLE: nxt_r.disp_cycle = wnew;
                OFS_STANDSTILL: nxt_r.standstill = wnew;
                OFS_REF_FREQ: nxt_r.ref_freq = wnew;
                OFS_REF_DISP: nxt_r.ref_disp = wnew;
                default: nxt_r.bresp = nxt_r.bresp;
            endcase
        end
        if (r_ff.bvalid && s_axi_bready) begin
            nxt_r.bvalid = 1'b0;
        end

        // Reads answer one cycle after the address is taken
        if (s_axi_arvalid && !r_ff.rvalid) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp = ssf_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr)
                OFS_CTRL: nxt_r.rdata = {23'h0, r_ff.sync, 5'h0, r_ff.mode};
                OFS_DISP_CYCLE: nxt_r.rdata = r_ff.disp_cycle;
                OFS_STANDSTILL: nxt_r.rdata = r_ff.standstill;
                OFS_REF_FREQ: nxt_r.rdata = r_ff.ref_freq;
                OFS_REF_DISP: nxt_r.rdata = r_ff.ref_disp;
                OFS_FILTERED: nxt_r.rdata = r_ff.filt;
                OFS_DISPLAYED: nxt_r.rdata = r_ff.disp;
                OFS_SAMPLE: nxt_r.rdata = r_ff.sample;
                default: nxt_r.rdata = 32'h0;
            endcase
        end else if (r_ff.rvalid && s_axi_rready) begin
            nxt_r.rvalid = 1'b0;
        end
        nxt_r.aw_rdy = !nxt_r.aw_got && !nxt_r.bvalid; // Ready as flops, no output decode
        nxt_r.w_rdy = !nxt_r.w_got && !nxt_r.bvalid;
        nxt_r.ar_rdy = !nxt_r.rvalid;
    end

    // State register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            r_ff <= '0;
            r_ff.state <= ST_IDLE;
            r_ff.mode <= MODE_RST;
            r_ff.applied_mode <= MODE_RST;
            r_ff.disp_cycle <= DISP_CYCLE_RST;
            r_ff.standstill <= STANDSTILL_RST;
            r_ff.ref_freq <= REF_FREQ_RST;
            r_ff.ref_disp <= REF_DISP_RST;
            {r_ff.aw_rdy, r_ff.w_rdy, r_ff.ar_rdy} <= 3'h7;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // Outputs straight from the state register
    assign display_value = r_ff.disp;
    assign display_strobe = r_ff.disp_stb;
    assign channel_sync_enable = r_ff.sync;
    assign s_axi_awready = r_ff.aw_rdy;
    assign s_axi_wready = r_ff.w_rdy;
    assign s_axi_bvalid = r_ff.bvalid;
    assign s_axi_bresp = r_ff.bresp;
    assign s_axi_arready = r_ff.ar_rdy;
    assign s_axi_rvalid = r_ff.rvalid;
    assign s_axi_rdata = r_ff.rdata;
    assign s_axi_rresp = r_ff.rresp;
endmodule // ssf_filter

// >>> ssf_pkg.sv
// Purpose: Shared constants for the speed smoothing filter block
// Assumes: 40 MHz mclk, AXI4-Lite register access with 32-bit data
// Notes: Register offsets are byte addresses on the register bus
package ssf_pkg;
    // Clock and time base
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
    // Standstill setting is in hundredths of a second
    localparam logic [63:0] STANDSTILL_SCALE = 64'h64;

    // Register map
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DISP_CYCLE = 8'h04;
    localparam logic [7:0] OFS_STANDSTILL = 8'h08;
    localparam logic [7:0] OFS_REF_FREQ = 8'h0C;
    localparam logic [7:0] OFS_REF_DISP = 8'h10;
    localparam logic [7:0] OFS_FILTERED = 8'h14;
    localparam logic [7:0] OFS_DISPLAYED = 8'h18;
    localparam logic [7:0] OFS_SAMPLE = 8'h1C;

    // Control register fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_MODE_W = 3;
    localparam int unsigned CTRL_SYNC_BIT = 8;

    // Reset values
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [31:0] DISP_CYCLE_RST = 32'h0000_03E8;
    localparam logic [31:0] STANDSTILL_RST = 32'h0000_0064;
    localparam logic [31:0] REF_FREQ_RST = 32'h0000_0001;
    localparam logic [31:0] REF_DISP_RST = 32'h0000_0001;

    // Filter settings
    localparam logic [2:0] FMODE_OFF = 3'h0;
    localparam logic [2:0] FMODE_AVG2 = 3'h1;
    localparam logic [2:0] FMODE_AVG8 = 3'h3;
    localparam logic [2:0] FMODE_EXP = 3'h5;
    localparam int unsigned AVG8_DEPTH = 8;
    localparam int unsigned AVG8_SHIFT = 3;
    localparam logic [3:0] AVG8_FULL = 4'h8;
    // Alpha 101/256 gives a time constant of two samples
    localparam logic [49:0] EXP_NUM = 50'h65;
    localparam int unsigned EXP_SHIFT = 8;

    // Divider
    localparam logic [6:0] DIV_STEPS = 7'h40;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Processing sequence
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_DIV = 3'h2,
        ST_FILT = 3'h4
    } ssf_state_t;
endpackage

// >>> ssf_hist_mem.sv
// Purpose: Sample history memory for the moving average
// Assumes: One write port, one read port, same clock
// Notes: Read data are registered, one cycle after the address
`timescale 1ns/1ps
module ssf_hist_mem #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW = 3
) (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_ff
);
    logic [WIDTH-1:0] mem [DEPTH];

    // No reset: contents are masked by the fill count until written
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end
endmodule // ssf_hist_mem

// >>> ssf_sva.sv
// Purpose: Port checks for the speed smoothing filter
// Assumes: MS_CYC of at least two cycles per display millisecond
// Notes: Bound to every ssf_filter instance
`timescale 1ns/1ps
module ssf_sva #(
    parameter int unsigned MS_CYC = 10
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [31:0] display_value,
    input wire logic display_strobe,
    input wire logic channel_sync_enable,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    logic [15:0] gap_ff;
    logic seen_ff;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    // Cycles since last refresh; first one is not judged
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gap_ff <= 16'h0000;
            seen_ff <= 1'b0;
        end else if (display_strobe) begin
            gap_ff <= 16'h0000;
            seen_ff <= 1'b1;
        end else if (gap_ff != 16'hFFFF) begin
            gap_ff <= gap_ff + 16'h0001;
        end
    end
    // Refresh pacing, display stability and sync enable changes
    AST_STROBE_PULSE: assert property (display_strobe |=> !display_strobe)
        else $error("display strobe longer than one cycle");
    AST_STROBE_GAP: assert property (display_strobe && seen_ff |-> 32'(gap_ff) >= MS_CYC - 1)
        else $error("display refreshed too soon");
    AST_DISP_ON_STROBE: assert property ($changed(display_value) |-> display_strobe)
        else $error("display value moved without a strobe");
    AST_SYNC_BY_WRITE: assert property ($changed(channel_sync_enable) |-> $rose(s_axi_bvalid))
        else $error("sync enable moved without a register write");
    // Register bus answers
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after address and data");
    AST_BVALID_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response held after acceptance");
    AST_WRITE_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready)
        else $error("read data not one cycle after address");
endmodule // ssf_sva

bind ssf_filter ssf_sva #(.MS_CYC(MS_CYC)) u_ssf_sva (
    .mclk(mclk), .resetn(resetn), .display_value(display_value),
    .display_strobe(display_strobe), .channel_sync_enable(channel_sync_enable),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid)
);

// >>> ssf_sensor_model.sv
// Purpose: Pulse-input side, one measured frequency per measuring cycle
// Assumes: Caller waits for emit to return before the next sample
// Notes: Frequency line carries inverted junk outside the valid pulse
`timescale 1ns/1ps
module ssf_sensor_model (
    output logic sample_valid,
    output logic [31:0] sample_freq,
    input wire logic mclk
);
    initial begin
        sample_valid = 1'b0;
        sample_freq = 32'h0000_0000;
    end
    // Pulse, then stay quiet longer than the 66-cycle spacing needs
    task automatic emit(input logic [31:0] f);
        @(posedge mclk);
        sample_valid <= 1'b1;
        sample_freq <= f;
        @(posedge mclk);
        sample_valid <= 1'b0;
        sample_freq <= ~f;
        repeat (70) @(posedge mclk);
    endtask
endmodule // ssf_sensor_model

// >>> ssf_filter_bench.sv
// Purpose: Self-checking bench for the speed smoothing filter
// Assumes: MS_CYC of 10, one display millisecond is ten cycles
// Notes: Filter result is read back over the register bus per sample
`timescale 1ns/1ps
module ssf_filter_bench;
    import ssf_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic sv, dstb, sync;
    logic [31:0] sf, dval, rdata;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int fails = 0;
    int checks = 0;
    ssf_filter #(.MS_CYC(10)) u_ssf_filter (
        .mclk(mclk), .resetn(resetn), .sample_valid(sv), .sample_freq(sf),
        .display_value(dval), .display_strobe(dstb), .channel_sync_enable(sync),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    ssf_sensor_model u_ssf_sensor_model (.sample_valid(sv), .sample_freq(sf), .mclk(mclk));
    // 40 MHz clock
    always #12.5 mclk = ~mclk;
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: value %0h, wanted %0h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: response %0h, wanted %0h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 200);
        r = (n < 200) ? bresp : 2'h3;
        bready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 200);
        chk_val(rdata, exp);
        chk_resp((n < 200) ? rresp : 2'h3, er);
        rready <= 1'b0;
    endtask
    task automatic set(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk_resp(r, RESP_OKAY);
    endtask
    // One measuring cycle, then the filter result
    task automatic send_chk(input logic [31:0] f, input logic [31:0] exp);
        u_ssf_sensor_model.emit(f);
        rd_chk(OFS_FILTERED, exp, RESP_OKAY);
    endtask
    task automatic t_regs();
        rd_chk(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFS_DISP_CYCLE, DISP_CYCLE_RST, RESP_OKAY);
        rd_chk(OFS_STANDSTILL, STANDSTILL_RST, RESP_OKAY);
        rd_chk(OFS_REF_FREQ, REF_FREQ_RST, RESP_OKAY);
        rd_chk(OFS_REF_DISP, REF_DISP_RST, RESP_OKAY);
        rd_chk(8'h20, 32'h0000_0000, RESP_SLVERR);
        // Only byte lane one may change
        wstrb <= 4'h2;
        set(OFS_REF_DISP, 32'hAAAA_5511);
        rd_chk(OFS_REF_DISP, 32'h0000_5501, RESP_OKAY);
        wstrb <= 4'hF;
        set(OFS_FILTERED, 32'hFFFF_FFFF);
        rd_chk(OFS_FILTERED, 32'h0000_0000, RESP_OKAY);
    endtask
    task automatic t_scale();
        set(OFS_REF_FREQ, 32'h0000_0070);
        set(OFS_REF_DISP, 32'h0000_0258);
        send_chk(32'h0000_0070, 32'h0000_0258);
        send_chk(32'h0000_0038, 32'h0000_012C);
        set(OFS_REF_FREQ, 32'h0000_0460);
        set(OFS_REF_DISP, 32'h0000_1770);
        send_chk(32'h0000_0038, 32'h0000_012C);
        rd_chk(OFS_SAMPLE, 32'h0000_012C, RESP_OKAY);
    endtask
    task automatic t_display();
        int n;
        int cnt;
        n = 0;
        cnt = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (dstb !== 1'b1 && n < 2000);
        chk_val(dval, 32'h0000_012C);
        repeat (100) begin
            @(posedge mclk);
            if (dstb === 1'b1) cnt++;
        end
        chk_val(32'(cnt), 32'h0000_000A);
        rd_chk(OFS_DISPLAYED, 32'h0000_012C, RESP_OKAY);
    endtask
    task automatic t_standstill();
        set(OFS_REF_FREQ, 32'h0000_0001);
        set(OFS_REF_DISP, 32'h0000_0001);
        set(OFS_STANDSTILL, 32'h0000_0014);
        send_chk(32'h0000_0004, 32'h0000_0000);
        send_chk(32'h0000_0005, 32'h0000_0005);
    endtask
    task automatic t_avg();
        set(OFS_CTRL, 32'(FMODE_AVG2));
        send_chk(32'h0000_0064, 32'h0000_0032);
        send_chk(32'h0000_0064, 32'h0000_0064);
        send_chk(32'h0000_00C8, 32'h0000_0096);
        send_chk(32'h0000_00C8, 32'h0000_00C8);
        set(OFS_CTRL, 32'(FMODE_AVG8));
        for (int k = 1; k <= 8; k++) begin
            send_chk(32'h0000_0320, 32'(k * 100));
        end
        send_chk(32'h0000_0000, 32'h0000_02BC);
        set(OFS_CTRL, 32'(FMODE_EXP));
        send_chk(32'h0000_0100, 32'h0000_0065);
        send_chk(32'h0000_0100, 32'h0000_00A2);
        set(OFS_CTRL, 32'h0000_0002);
        send_chk(32'h0000_0100, 32'h0000_0100);
    endtask
    task automatic t_sync();
        set(OFS_CTRL, 32'h0000_0100);
        chk_val({31'h0, sync}, 32'h0000_0001);
        rd_chk(OFS_CTRL, 32'h0000_0100, RESP_OKAY);
        set(OFS_CTRL, 32'h0000_0000);
        chk_val({31'h0, sync}, 32'h0000_0000);
    endtask
    // Reset in mid-run brings settings and display back to their defaults
    task automatic t_reset();
        set(OFS_CTRL, 32'h0000_0103);
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        rd_chk(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFS_DISP_CYCLE, DISP_CYCLE_RST, RESP_OKAY);
        rd_chk(OFS_DISPLAYED, 32'h0000_0000, RESP_OKAY);
        chk_val({31'h0, sync}, 32'h0000_0000);
    endtask
    task automatic print_verdict();
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence, display period shortened to one millisecond
    initial begin
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        t_regs();
        set(OFS_DISP_CYCLE, 32'h0000_0001);
        t_scale();
        t_display();
        t_standstill();
        t_avg();
        t_sync();
        t_reset();
        print_verdict();
    end
    // Hang guard, several times the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        $display("unexpected at %0t: run did not finish", $time);
        print_verdict();
    end
endmodule // ssf_filter_bench
